// [shared/cmr_defs.vh]
// constants for the cell monitor limit, balance and gate register bank
`ifndef CMR_DEFS_VH
`define CMR_DEFS_VH

`define CMR_CLK_KHZ         64'd200000
`define CMR_STEP_MS         64'd71500
`define CMR_STEP_CYCLES     (`CMR_STEP_MS * `CMR_CLK_KHZ)
`define CMR_ALERT_F0_HZ     64'd100
`define CMR_ALERT_F1_HZ     64'd1000
`define CMR_ALERT_F2_HZ     64'd10000
`define CMR_HALF_CYCLES(f)  ((`CMR_CLK_KHZ * 64'd1000) / (64'd2 * (f)))

`define CMR_A_CTRL_HI       6'h0D
`define CMR_A_CTRL_LO       6'h0E
`define CMR_A_CELL_HI       6'h0F
`define CMR_A_CELL_LO       6'h10
`define CMR_A_AUX_HI        6'h11
`define CMR_A_AUX_LO        6'h12
`define CMR_A_ALERT         6'h13
`define CMR_A_BAL           6'h14
`define CMR_A_TMR0          6'h15
`define CMR_A_PD_TMR        6'h1B
`define CMR_A_READ          6'h1C
`define CMR_A_GATE          6'h1D

`define CMR_RST_CTRL_HI     8'h00
`define CMR_RST_CTRL_LO     8'h13
`define CMR_RST_HIGH_TH     8'hFF
`define CMR_RST_ZERO        8'h00

`define CMR_CTRL_HI_TRIG    3
`define CMR_CTRL_LO_SWRST   7
`define CMR_BAL_LSB         2
`define CMR_CODE_MSB        7
`define CMR_CODE_LSB        3
`define CMR_GATE_HOLD       0
`define CMR_GATE_ONE        1
`define CMR_ALERT_FREQ_MSB  1
`define CMR_ALERT_MODE_MSB  3
`define CMR_ALERT_MODE_LSB  2

`define CMR_MODE_STATIC     2'h0
`define CMR_MODE_DYNAMIC    2'h1
`define CMR_MODE_PASS       2'h2

`endif

// [rtl/cmr_regs.v]
// cell monitor limit, alert, balance, shutdown and convert gate register bank
//
// Overview of operation
// - Cell result above cell high threshold (reset 0xFF, 16 mV step) raises alert.
// - Cell result below cell low threshold (reset 0x00) raises alert.
// - Aux result above aux high threshold (reset 0xFF, 19 mV step) raises alert.
// - Aux result below aux low threshold (reset 0x00) raises alert.
// - Static alert: output high while clean, low once any violation occurred.
// - Dynamic alert: square wave at 100 Hz, 1 kHz or 10 kHz while clean, low once any violation occurred.
// - Pass-through forwards incoming alert, forces low on own violation.
// - Balance bits 7..2 drive outputs six..one, 1 on; bits 1..0 zero.
// - Balance register zero at reset, software reset and hardware power-down.
// - Balance timer code in bits 7..3, 71.5 s per step; low bits zero.
// - Zero timer code: output follows balance bit only.
// - Shutdown timer code bits 7..3, 71.5 s steps, powers device down.
// - Shutdown timer beats balance timers; host sets it one step longer.
// - Readback selector holds 6-bit address in bits 7..2, reset zero.
// - Host writes target address for readback; zero returns conversion series.
// - Gate bit 0 set holds internal convert start high.
// - Gate bits 10 pass exactly one falling edge, then block.
// - Gate register resets to zero: pin passes ungated.
// - Control bit 11 picks pin or select-line trigger; clears after software start.
// - Control bit 7 holds software reset; all but control low byte restored.
`timescale 1ns/10ps
`include "cmr_defs.vh"

module cmr_regs #(
    parameter [63:0] STEP_CYCLES = `CMR_STEP_CYCLES,
    parameter [63:0] HALF_F0     = `CMR_HALF_CYCLES(`CMR_ALERT_F0_HZ),
    parameter [63:0] HALF_F1     = `CMR_HALF_CYCLES(`CMR_ALERT_F1_HZ),
    parameter [63:0] HALF_F2     = `CMR_HALF_CYCLES(`CMR_ALERT_F2_HZ)
) (
    input  wire        MCLK,
    input  wire        RST_N,
    input  wire        REG_WR,
    input  wire [5:0]  REG_ADDR,
    input  wire [7:0]  REG_WDATA,
    output reg  [7:0]  REG_RDATA,
    output wire        RESULT_SERIES,
    input  wire        CONV_VALID,
    input  wire        CONV_IS_AUX,
    input  wire [11:0] CONV_DATA,
    input  wire        ALERT_IN,
    output reg         ALERT_OUT,
    output wire [5:0]  BALANCE_OUTPUTS,
    input  wire        HW_POWER_DOWN,
    output reg         POWER_DOWN_REQUEST,
    input  wire        CONVERT_START_PIN_N,
    output reg         CONVERT_START_INT_N,
    input  wire        SOFT_START,
    output wire        TRIGGER_ON_SELECT
);

    reg  [7:0]  ctrl_hi_q;
    reg  [7:0]  ctrl_lo_q;
    reg  [7:0]  cell_hi_q;
    reg  [7:0]  cell_lo_q;
    reg  [7:0]  aux_hi_q;
    reg  [7:0]  aux_lo_q;
    reg  [7:0]  alert_cfg_q;
    reg  [7:0]  bal_q;
    reg  [7:0]  tmr_q [0:5];
    reg  [4:0]  tmr_cnt_q [0:5];
    reg  [7:0]  pd_tmr_q;
    reg  [4:0]  pd_cnt_q;
    reg  [7:0]  read_q;
    reg  [7:0]  gate_q;
    reg         window_q;
    reg         window_fall_q;
    reg         pin_prev_q;
    reg         violated_q;
    reg  [63:0] step_cnt_q;
    reg  [63:0] wave_cnt_q;
    reg         wave_q;
    reg  [63:0] wave_half;
    reg  [7:0]  rd_d;
    integer     i;

    wire        sw_rst = ctrl_lo_q[`CMR_CTRL_LO_SWRST];
    wire        wr     = REG_WR & ~sw_rst;
    wire        step   = (step_cnt_q == STEP_CYCLES - 64'd1);
    wire [7:0]  res8   = CONV_DATA[11:4];
    wire        pd_fire = step & (pd_tmr_q[7:3] != 5'h00) & (pd_cnt_q == 5'h01);
    wire        pd_event = HW_POWER_DOWN | pd_fire;
    wire [1:0]  alert_mode = alert_cfg_q[`CMR_ALERT_MODE_MSB:`CMR_ALERT_MODE_LSB];
    wire        pin_fall = pin_prev_q & ~CONVERT_START_PIN_N;
    wire        pin_rise = ~pin_prev_q & CONVERT_START_PIN_N;

    function [4:0] code_of;
        input [7:0] r;
        begin
            code_of = r[`CMR_CODE_MSB:`CMR_CODE_LSB];
        end
    endfunction

    function is_wr;
        input       w;
        input [5:0] a;
        input [5:0] t;
        begin
            is_wr = w & (a == t);
        end
    endfunction

    assign BALANCE_OUTPUTS   = bal_q[7:2];
    assign RESULT_SERIES     = (read_q[7:2] == 6'h00);
    assign TRIGGER_ON_SELECT = ctrl_hi_q[`CMR_CTRL_HI_TRIG];

    // control register; low byte survives software reset
    always @(posedge MCLK) begin
        if (!RST_N) begin
            ctrl_hi_q <= `CMR_RST_CTRL_HI;
            ctrl_lo_q <= `CMR_RST_CTRL_LO;
        end else begin
            if (REG_WR && REG_ADDR == `CMR_A_CTRL_LO)
                ctrl_lo_q <= REG_WDATA;
            if (sw_rst)
                ctrl_hi_q <= `CMR_RST_CTRL_HI;
            else if (is_wr(wr, REG_ADDR, `CMR_A_CTRL_HI))
                ctrl_hi_q <= REG_WDATA;
            else if (SOFT_START && ctrl_hi_q[`CMR_CTRL_HI_TRIG])
                ctrl_hi_q[`CMR_CTRL_HI_TRIG] <= 1'b0;
        end
    end

    // plain configuration registers
    always @(posedge MCLK) begin
        if (!RST_N || sw_rst) begin
            cell_hi_q   <= `CMR_RST_HIGH_TH;
            cell_lo_q   <= `CMR_RST_ZERO;
            aux_hi_q    <= `CMR_RST_HIGH_TH;
            aux_lo_q    <= `CMR_RST_ZERO;
            alert_cfg_q <= `CMR_RST_ZERO;
            read_q      <= `CMR_RST_ZERO;
            pd_tmr_q    <= `CMR_RST_ZERO;
            for (i = 0; i < 6; i = i + 1)
                tmr_q[i] <= `CMR_RST_ZERO;
        end else begin
            if (is_wr(wr, REG_ADDR, `CMR_A_CELL_HI)) cell_hi_q <= REG_WDATA;
            if (is_wr(wr, REG_ADDR, `CMR_A_CELL_LO)) cell_lo_q <= REG_WDATA;
            if (is_wr(wr, REG_ADDR, `CMR_A_AUX_HI)) aux_hi_q <= REG_WDATA;
            if (is_wr(wr, REG_ADDR, `CMR_A_AUX_LO)) aux_lo_q <= REG_WDATA;
            if (is_wr(wr, REG_ADDR, `CMR_A_ALERT)) alert_cfg_q <= REG_WDATA;
            if (is_wr(wr, REG_ADDR, `CMR_A_READ))
                read_q <= {REG_WDATA[7:2], 2'b00};
            if (is_wr(wr, REG_ADDR, `CMR_A_PD_TMR))
                pd_tmr_q <= {code_of(REG_WDATA), 3'b000};
            for (i = 0; i < 6; i = i + 1)
                if (is_wr(wr, REG_ADDR, `CMR_A_TMR0 + i[5:0]))
                    tmr_q[i] <= {code_of(REG_WDATA), 3'b000};
        end
    end

    // step prescaler shared by all minute-scale timers
    always @(posedge MCLK) begin
        if (!RST_N || step)
            step_cnt_q <= 64'd0;
        else
            step_cnt_q <= step_cnt_q + 64'd1;
    end

    // balance bits with per-output countdown; power-down wins
    always @(posedge MCLK) begin
        if (!RST_N || sw_rst || pd_event) begin
            bal_q <= `CMR_RST_ZERO;
            for (i = 0; i < 6; i = i + 1)
                tmr_cnt_q[i] <= 5'h00;
        end else begin
            if (is_wr(wr, REG_ADDR, `CMR_A_BAL))
                bal_q <= {REG_WDATA[7:2], 2'b00};
            for (i = 0; i < 6; i = i + 1) begin
                if (!bal_q[`CMR_BAL_LSB + i] || code_of(tmr_q[i]) == 5'h00) begin
                    tmr_cnt_q[i] <= code_of(tmr_q[i]);
                end else if (step) begin
                    if (tmr_cnt_q[i] <= 5'h01)
                        bal_q[`CMR_BAL_LSB + i] <= 1'b0;
                    else
                        tmr_cnt_q[i] <= tmr_cnt_q[i] - 5'h01;
                end
            end
        end
    end

    // shutdown countdown, restarted by each write of its register
    always @(posedge MCLK) begin
        if (!RST_N || sw_rst) begin
            pd_cnt_q           <= 5'h00;
            POWER_DOWN_REQUEST <= 1'b0;
        end else if (is_wr(wr, REG_ADDR, `CMR_A_PD_TMR)) begin
            pd_cnt_q           <= code_of(REG_WDATA);
            POWER_DOWN_REQUEST <= pd_fire;
        end else begin
            if (pd_fire)
                POWER_DOWN_REQUEST <= 1'b1;
            if (step && pd_cnt_q != 5'h00)
                pd_cnt_q <= pd_cnt_q - 5'h01;
        end
    end

    // sticky limit violation
    always @(posedge MCLK) begin
        if (!RST_N || sw_rst)
            violated_q <= 1'b0;
        else if (CONV_VALID && !CONV_IS_AUX && (res8 > cell_hi_q || res8 < cell_lo_q))
            violated_q <= 1'b1;
        else if (CONV_VALID && CONV_IS_AUX && (res8 > aux_hi_q || res8 < aux_lo_q))
            violated_q <= 1'b1;
    end

    always @* begin
        case (alert_cfg_q[`CMR_ALERT_FREQ_MSB:0])
            2'h0:    wave_half = HALF_F0;
            2'h1:    wave_half = HALF_F1;
            default: wave_half = HALF_F2;
        endcase
    end

    // alert square wave and output select
    always @(posedge MCLK) begin
        if (!RST_N || sw_rst) begin
            wave_cnt_q <= 64'd0;
            wave_q     <= 1'b1;
            ALERT_OUT  <= 1'b1;
        end else begin
            if (wave_cnt_q >= wave_half - 64'd1) begin
                wave_cnt_q <= 64'd0;
                wave_q     <= ~wave_q;
            end else begin
                wave_cnt_q <= wave_cnt_q + 64'd1;
            end
            if (violated_q)
                ALERT_OUT <= 1'b0;
            else case (alert_mode)
                `CMR_MODE_STATIC:  ALERT_OUT <= 1'b1;
                `CMR_MODE_DYNAMIC: ALERT_OUT <= wave_q;
                `CMR_MODE_PASS:    ALERT_OUT <= ALERT_IN;
                default:           ALERT_OUT <= 1'b1;
            endcase
        end
    end

    // convert start gate and single-pulse window
    always @(posedge MCLK) begin
        if (!RST_N || sw_rst) begin
            gate_q              <= `CMR_RST_ZERO;
            window_q            <= 1'b0;
            window_fall_q       <= 1'b0;
            pin_prev_q          <= 1'b1;
            CONVERT_START_INT_N <= 1'b1;
        end else begin
            pin_prev_q <= CONVERT_START_PIN_N;
            if (is_wr(wr, REG_ADDR, `CMR_A_GATE)) begin
                gate_q        <= REG_WDATA;
                window_q      <= REG_WDATA[`CMR_GATE_ONE] & ~REG_WDATA[`CMR_GATE_HOLD];
                window_fall_q <= 1'b0;
            end else if (window_q && pin_fall) begin
                window_fall_q <= 1'b1;
            end else if (window_fall_q && pin_rise) begin
                window_q      <= 1'b0;
                window_fall_q <= 1'b0;
            end
            if (gate_q[`CMR_GATE_HOLD])
                CONVERT_START_INT_N <= 1'b1;
            else if (gate_q[`CMR_GATE_ONE])
                CONVERT_START_INT_N <= CONVERT_START_PIN_N |
                                       ~(window_q & (pin_fall | window_fall_q));
            else
                CONVERT_START_INT_N <= CONVERT_START_PIN_N;
        end
    end

    // register addressed by the readback selector
    always @* begin
        rd_d = 8'h00;
        case (read_q[7:2])
            `CMR_A_CTRL_HI: rd_d = ctrl_hi_q;
            `CMR_A_CTRL_LO: rd_d = ctrl_lo_q;
            `CMR_A_CELL_HI: rd_d = cell_hi_q;
            `CMR_A_CELL_LO: rd_d = cell_lo_q;
            `CMR_A_AUX_HI:  rd_d = aux_hi_q;
            `CMR_A_AUX_LO:  rd_d = aux_lo_q;
            `CMR_A_ALERT:   rd_d = alert_cfg_q;
            `CMR_A_BAL:     rd_d = bal_q;
            `CMR_A_PD_TMR:  rd_d = pd_tmr_q;
            `CMR_A_READ:    rd_d = read_q;
            `CMR_A_GATE:    rd_d = gate_q;
            default: begin
                for (i = 0; i < 6; i = i + 1)
                    if (read_q[7:2] == `CMR_A_TMR0 + i[5:0])
                        rd_d = tmr_q[i];
            end
        endcase
    end

    always @(posedge MCLK) begin
        if (!RST_N)
            REG_RDATA <= 8'h00;
        else
            REG_RDATA <= rd_d;
    end

endmodule // cmr_regs

// [verification/cmr_props.sv]
// checker for the cell monitor register bank ports
`timescale 1ns/10ps
`include "cmr_defs.vh"
module cmr_props (
    input wire        MCLK,
    input wire        RST_N,
    input wire        REG_WR,
    input wire [5:0]  REG_ADDR,
    input wire [7:0]  REG_WDATA,
    input wire        RESULT_SERIES,
    input wire [5:0]  BALANCE_OUTPUTS,
    input wire        HW_POWER_DOWN,
    input wire        CONVERT_START_PIN_N,
    input wire        CONVERT_START_INT_N,
    input wire        SOFT_START,
    input wire        TRIGGER_ON_SELECT
);
    reg       swr_q;
    reg       used_q;
    reg [1:0] gate_q;
    wire      wok = REG_WR && !swr_q;
    wire      g10 = gate_q == 2'h2;
    // shadow of soft reset, gate mode and single-pulse window
    always @(posedge MCLK) begin
        if (!RST_N) begin
            swr_q <= 1'b0;
        end else if (REG_WR && REG_ADDR == `CMR_A_CTRL_LO) begin
            swr_q <= REG_WDATA[`CMR_CTRL_LO_SWRST];
        end
        if (!RST_N || swr_q) begin
            gate_q <= 2'h0;
            used_q <= 1'b0;
        end else if (wok && REG_ADDR == `CMR_A_GATE) begin
            gate_q <= REG_WDATA[1:0];
            used_q <= 1'b0;
        end else if (g10 && $fell(CONVERT_START_PIN_N)) begin
            used_q <= 1'b1;
        end
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    sequence pin_fall;
        $fell(CONVERT_START_PIN_N);
    endsequence
    sequence pin_high_seen;
        CONVERT_START_PIN_N || $past(CONVERT_START_PIN_N);
    endsequence
    a_bal_no_stray: assert property (wok && REG_ADDR == `CMR_A_BAL |=>
        (BALANCE_OUTPUTS & ~$past(REG_WDATA[7:2])) == 6'h00) else $error("stray balance bit");
    a_hw_pd_clear: assert property (HW_POWER_DOWN && !REG_WR |=>
        BALANCE_OUTPUTS == 6'h00) else $error("balance kept in power-down");
    a_gate_hold: assert property (gate_q[0] |=> CONVERT_START_INT_N)
        else $error("gated start not held high");
    a_gate_open: assert property (gate_q == 2'h0 |=>
        CONVERT_START_INT_N == $past(CONVERT_START_PIN_N)) else $error("ungated pin lost");
    a_one_pulse: assert property ((g10 && !used_q) ##0 pin_fall |=>
        !CONVERT_START_INT_N) else $error("window pulse not passed");
    a_window_shut: assert property ((g10 && used_q) ##0 pin_high_seen |=>
        CONVERT_START_INT_N) else $error("closed window let pulse pass");
    a_start_clear: assert property (SOFT_START && !(REG_WR && REG_ADDR == `CMR_A_CTRL_HI)
        |=> !TRIGGER_ON_SELECT) else $error("trigger bit kept after start");
    a_series_flag: assert property (wok && REG_ADDR == `CMR_A_READ |=>
        RESULT_SERIES == ($past(REG_WDATA[7:2]) == 6'h00)) else $error("series flag wrong");
endmodule // cmr_props

// [verification/cmr_host.sv]
// host model: register writes, selector readback and soft reset
`timescale 1ns/10ps
`include "cmr_defs.vh"
module cmr_host (
    input  wire       mclk,
    input  wire [7:0] rdata,
    output reg        wr,
    output reg  [5:0] addr,
    output reg  [7:0] wdata
);
    initial begin
        wr = 1'b0;
        addr = 6'h3F;
        wdata = 8'hFF;
    end
    task wr_reg(input [5:0] a, input [7:0] d);
        begin
            @(negedge mclk);
            wr = 1'b1;
            addr = a;
            wdata = d;
            @(negedge mclk);
            wr = 1'b0;
            addr = ~a;
            wdata = ~d;
        end
    endtask
    task rd_reg(input [5:0] a, output [7:0] d);
        begin
            wr_reg(`CMR_A_READ, {a, 2'h0});
            repeat (2) @(negedge mclk);
            d = rdata;
        end
    endtask
    task sw_reset;
        begin
            wr_reg(`CMR_A_CTRL_LO, 8'h93);
            wr_reg(`CMR_A_CTRL_LO, 8'h13);
        end
    endtask
endmodule // cmr_host

// [verification/tb.sv]
// self-checking bench for the cell monitor register bank
`timescale 1ns/10ps
`include "cmr_defs.vh"
module tb;
    localparam STEP = 16;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg         conv_valid = 1'b0;
    reg         conv_aux = 1'b0;
    reg  [11:0] conv_data = 12'h000;
    reg         alert_in = 1'b1;
    reg         hw_pd = 1'b0;
    reg         soft_start = 1'b0;
    reg         pin_n = 1'b1;
    wire        reg_wr;
    wire [5:0]  reg_addr;
    wire [7:0]  reg_wdata;
    wire [7:0]  rdata;
    wire        alert_out;
    wire [5:0]  bal;
    wire        pd_req;
    wire        int_n;
    wire        trig_sel;
    wire        series;
    integer     fail_count = 0;
    integer     n_tests = 0;
    integer     cyc = 0;
    integer     i;
    integer     n;
    reg  [7:0]  rd;
    reg  [1:0]  s;
    reg         prev;
    // addr, reset value, write data, readback
    reg  [31:0] rows [0:9] = '{32'h0FFFA5A5, 32'h10005A5A, 32'h11FF3C3C, 32'h1200C3C3,
        32'h1500FFF8, 32'h1400FFFC, 32'h1B000700, 32'h1D00FFFF, 32'h3F005500, 32'h0E131313};
    reg  [9:0]  gates [0:2] = '{10'h000, 10'h007, 10'h009};
    // aux, violation, conversion result
    reg  [13:0] convs [0:5] = '{14'h1810, 14'h13FF, 14'h0800, 14'h3810, 14'h33FF, 14'h2400};
    always #2.5 mclk = ~mclk;
    cmr_host cmr_host_inst (.mclk(mclk), .rdata(rdata), .wr(reg_wr), .addr(reg_addr),
        .wdata(reg_wdata));
    cmr_regs #(.STEP_CYCLES(STEP), .HALF_F0(8), .HALF_F1(4), .HALF_F2(2)) cmr_regs_inst (
        .MCLK(mclk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .RESULT_SERIES(series),
        .CONV_VALID(conv_valid),
        .CONV_IS_AUX(conv_aux), .CONV_DATA(conv_data), .ALERT_IN(alert_in),
        .ALERT_OUT(alert_out), .BALANCE_OUTPUTS(bal), .HW_POWER_DOWN(hw_pd),
        .POWER_DOWN_REQUEST(pd_req), .CONVERT_START_PIN_N(pin_n),
        .CONVERT_START_INT_N(int_n), .SOFT_START(soft_start), .TRIGGER_ON_SELECT(trig_sel));
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task pulse(output sd);
        begin
            @(negedge mclk) pin_n = 1'b0;
            @(negedge mclk) sd = int_n;
            @(negedge mclk) pin_n = 1'b1;
            repeat (2) @(negedge mclk);
        end
    endtask
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            fail_count = fail_count + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (10) @(negedge mclk);
        chk("reset_outs", {4'h0, series, alert_out, int_n, trig_sel}, 8'h0E);
        rst_n = 1'b1;
        for (i = 0; i < 10; i = i + 1) begin
            cmr_host_inst.rd_reg(rows[i][29:24], rd);
            chk("reset_value", rd, rows[i][23:16]);
        end
        for (i = 0; i < 10; i = i + 1) begin
            cmr_host_inst.wr_reg(rows[i][29:24], rows[i][15:8]);
            cmr_host_inst.rd_reg(rows[i][29:24], rd);
            chk("readback", rd, rows[i][7:0]);
        end
        chk("bal_all", {2'h0, bal}, 8'h3F);
        cmr_host_inst.wr_reg(`CMR_A_CTRL_LO, 8'h93);
        cmr_host_inst.wr_reg(`CMR_A_CELL_HI, 8'h11);
        cmr_host_inst.wr_reg(`CMR_A_CTRL_LO, 8'h13);
        chk("swr_bal", {2'h0, bal}, 8'h00);
        cmr_host_inst.rd_reg(`CMR_A_CELL_HI, rd);
        chk("swr_cell_hi", rd, 8'hFF);
        cmr_host_inst.wr_reg(`CMR_A_TMR0, 8'h10);
        cmr_host_inst.wr_reg(`CMR_A_BAL, 8'h0C);
        chk("bal_on", {2'h0, bal}, 8'h03);
        repeat (3 * STEP) @(negedge mclk);
        chk("bal_timer", {2'h0, bal}, 8'h02);
        cmr_host_inst.wr_reg(`CMR_A_PD_TMR, 8'h08);
        repeat (2 * STEP + 2) @(negedge mclk);
        chk("pd_req", {2'h0, bal, pd_req}, 8'h01);
        cmr_host_inst.wr_reg(`CMR_A_PD_TMR, 8'h00);
        cmr_host_inst.wr_reg(`CMR_A_BAL, 8'hFC);
        chk("pd_clear", {7'h00, pd_req}, 8'h00);
        @(negedge mclk) hw_pd = 1'b1;
        @(negedge mclk) hw_pd = 1'b0;
        chk("hw_pd", {2'h0, bal}, 8'h00);
        for (i = 0; i < 3; i = i + 1) begin
            cmr_host_inst.wr_reg(`CMR_A_GATE, gates[i][9:2]);
            pulse(s[1]);
            pulse(s[0]);
            chk("gate_pulses", {6'h00, s}, {6'h00, gates[i][1:0]});
        end
        cmr_host_inst.wr_reg(`CMR_A_GATE, 8'h01);
        cmr_host_inst.wr_reg(`CMR_A_CTRL_HI, 8'h08);
        chk("trig_sel", {7'h00, trig_sel}, 8'h01);
        @(negedge mclk) soft_start = 1'b1;
        @(negedge mclk) soft_start = 1'b0;
        chk("trig_clear", {7'h00, trig_sel}, 8'h00);
        for (i = 0; i < 6; i = i + 1) begin
            cmr_host_inst.sw_reset;
            for (n = 0; n < 4; n = n + 1)
                cmr_host_inst.wr_reg(`CMR_A_CELL_HI + n, n[0] ? 8'h40 : 8'h80);
            conv_aux = convs[i][13];
            conv_data = convs[i][11:0];
            @(negedge mclk) conv_valid = 1'b1;
            @(negedge mclk) conv_valid = 1'b0;
            repeat (2) @(negedge mclk);
            chk("alert", {7'h00, alert_out}, {7'h00, ~convs[i][12]});
            repeat (4) @(negedge mclk);
        end
        cmr_host_inst.sw_reset;
        cmr_host_inst.wr_reg(`CMR_A_ALERT, 8'h08);
        @(negedge mclk) alert_in = 1'b0;
        repeat (2) @(negedge mclk);
        chk("pass_low", {7'h00, alert_out}, 8'h00);
        alert_in = 1'b1;
        repeat (2) @(negedge mclk);
        chk("pass_high", {7'h00, alert_out}, 8'h01);
        for (i = 0; i < 3; i = i + 1) begin
            cmr_host_inst.wr_reg(`CMR_A_ALERT, 8'h04 + i);
            n = 0;
            prev = alert_out;
            repeat (64) begin
                @(negedge mclk);
                n = n + (alert_out !== prev);
                prev = alert_out;
            end
            chk("wave", {7'h00, n >= (8 << i) - 1 && n <= (8 << i) + 1}, 8'h01);
        end
        give_verdict;
    end
endmodule // tb
bind cmr_regs cmr_props cmr_props_inst (.MCLK(MCLK), .RST_N(RST_N), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .RESULT_SERIES(RESULT_SERIES),
    .BALANCE_OUTPUTS(BALANCE_OUTPUTS), .HW_POWER_DOWN(HW_POWER_DOWN),
    .CONVERT_START_PIN_N(CONVERT_START_PIN_N), .CONVERT_START_INT_N(CONVERT_START_INT_N),
    .SOFT_START(SOFT_START), .TRIGGER_ON_SELECT(TRIGGER_ON_SELECT));
